// ---- msg_port_device.sv ----
/*
 * device end: serial slave for fixed message frames, reply-ready
 * flag, interrupt, system-valid, fan, shutdown and led stream strobes.
 * assumes link_clk is the device clock and user inputs are on it.
 */
// Overview of operation
// RULE_01: host clocks serial port at most 400 kHz
// RULE_02: device may stretch clock; host honours it
// RULE_03: every message is fifteen bytes long
// RULE_04: reply ready driven low when reply waits
// RULE_05: host reads only while reply ready low
// RULE_06: reply ready returns high after reply read
// RULE_07: interrupt low while configured event in progress
// RULE_08: shutdown input low turns all ports off
// RULE_09: system valid follows software mask of conditions
// RULE_10: active-high fan control output provided
// RULE_11: led select, latch, enable strobes active low
// RULE_12: analog level picks address or uart mode
// RULE_13: led stream clocked out at 1 MHz
// RULE_14: reply ready high after reset, when idle
`timescale 1ns/1ps
module msg_port_device
  import msg_port_pkg::*;
(
  // clock and reset
  input  wire logic                link_clk,
  input  wire logic                rst_n,
  // serial link
  host_link_if.device              link,
  // message user side
  output      msg_port_pkg::frame_type cmd_frame,
  output      logic                cmd_valid,
  input  wire msg_port_pkg::frame_type reply_frame,
  input  wire logic                reply_load,
  output      logic                reply_pending,
  // address strap
  input  wire logic [7:0]          address_select_level_in,
  output      logic                uart_mode,
  // system signals
  input  wire logic [7:0]          event_active,
  input  wire logic [7:0]          event_enable,
  input  wire logic [7:0]          sys_cond_ok,
  input  wire logic [7:0]          sys_mask,
  input  wire logic                fan_request,
  input  wire logic                port_shutdown_n,
  output      logic                ports_off,
  output      logic                fan_on,
  output      logic                system_valid_n,
  // led stream
  input  wire logic [15:0]         led_pattern,
  input  wire logic                led_enable,
  output      logic                manager_bus_clock,
  output      logic                led_serial_data,
  output      logic                led_select_n,
  output      logic                led_latch_n,
  output      logic                led_output_enable_n
);
  import msg_port_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK_A, S_RX, S_ACK_R, S_TX, S_ACK_T, S_HOLD
  } slv_state_type;

  typedef struct packed {
    slv_state_type st;
    logic          scl_s1;
    logic          scl_s2;
    logic          scl_d;
    logic          sda_s1;
    logic          sda_s2;
    logic          sda_d;
    logic          dis_s1;
    logic          dis_s2;
    logic [7:0]    sh;
    logic [3:0]    bits;
    logic [3:0]    idx;
    logic          rw;
    logic          nack;
    logic          ovr;
    logic          pend_n;
    frame_type     cmd;
    frame_type     rep;
    logic          cmd_v;
    logic          scl_oe;
    logic          sda_oe;
    logic          strapped;
    logic          uart;
    logic [6:0]    addr;
    logic          irq_n;
    logic          sysv_n;
    logic          fan;
    logic          off;
    logic [LED_DIV_W-1:0] ldiv;
    logic          lclk;
    logic [4:0]    lbit;
    logic [15:0]   lpat;
    logic          lsel_n;
    logic          llat_n;
    logic          loe_n;
    logic          ldat;
  } dev_state_type;

  dev_state_type r;
  dev_state_type n;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  //////////////////////////////////////////////////////////////////////////
  // bus events, all taken from the second synchroniser stage onward
  assign rise  = r.scl_s2 & ~r.scl_d;
  assign fall  = ~r.scl_s2 & r.scl_d;
  assign start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
  assign stop  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;

  always_comb begin
    n = r;
    n.cmd_v  = 1'b0;
    n.scl_s1 = link.host_serial_clock;
    n.scl_s2 = r.scl_s1;
    n.scl_d  = r.scl_s2;
    n.sda_s1 = link.host_serial_data;
    n.sda_s2 = r.sda_s1;
    n.sda_d  = r.sda_s2;
    n.dis_s1 = port_shutdown_n;
    n.dis_s2 = r.dis_s1;

    // strap caught once, on the first edge after reset release
    if (!r.strapped) begin
      n.strapped = 1'b1;
      n.uart = (address_select_level_in <= UART_LEVEL_MAX); // RULE_12
      n.addr = ADDR_BASE + {4'h0, address_select_level_in[7:5]}; // RULE_12
    end

    // side-band outputs
    n.irq_n  = ~|(event_active & event_enable); // RULE_07
    n.sysv_n = ~&(sys_cond_ok | ~sys_mask); // RULE_09
    n.fan    = fan_request; // RULE_10
    n.off    = ~r.dis_s2; // RULE_08

    //////////////////////////////////////////////////////////////////////
    // serial slave
    case (r.st)
      S_ADDR: begin
        if (rise) begin
          n.sh   = {r.sh[6:0], r.sda_s2};
          n.bits = r.bits + 4'h1;
        end else if (fall && r.bits == 4'h8) begin
          if (r.sh[7:1] == r.addr) begin
            n.st     = S_ACK_A;
            n.sda_oe = 1'b1;
            n.rw     = r.sh[0];
          end else begin
            n.st = S_IDLE;
          end
        end
      end
      S_ACK_A: begin
        if (fall) begin
          n.sda_oe = 1'b0;
          n.bits   = CNT_RST;
          n.idx    = CNT_RST;
          n.ovr    = 1'b0;
          if (!r.rw) begin
            n.st = S_RX;
          end else if (!r.pend_n) begin
            n.sh     = r.rep[0];
            n.sda_oe = ~r.rep[0][7];
            n.bits   = 4'h1;
            n.st     = S_TX;
          end else begin
            // nothing to send yet: hold the clock low until a reply loads
            n.scl_oe = 1'b1; // RULE_02
            n.st     = S_HOLD;
          end
        end
      end
      S_HOLD: begin
        if (!r.pend_n) begin
          n.scl_oe = 1'b0; // RULE_02
          n.sh     = r.rep[0];
          n.sda_oe = ~r.rep[0][7];
          n.bits   = 4'h1;
          n.st     = S_TX;
        end
      end
      S_RX: begin
        if (rise) begin
          n.sh   = {r.sh[6:0], r.sda_s2};
          n.bits = r.bits + 4'h1;
        end else if (fall && r.bits == 4'h8) begin
          n.st = S_ACK_R;
          if (r.idx < 4'(FRAME_BYTES)) begin
            n.cmd[r.idx] = r.sh; // RULE_03
            n.idx        = r.idx + 4'h1;
            n.sda_oe     = 1'b1;
          end else begin
            // a sixteenth byte is refused and spoils the frame
            n.ovr = 1'b1; // RULE_03
          end
        end
      end
      S_ACK_R: begin
        if (fall) begin
          n.sda_oe = 1'b0;
          n.bits   = CNT_RST;
          n.st     = S_RX;
        end
      end
      S_TX: begin
        if (fall) begin
          if (r.bits < 4'h8) begin
            n.sh     = {r.sh[6:0], 1'b0};
            n.sda_oe = ~r.sh[6];
            n.bits   = r.bits + 4'h1;
          end else begin
            n.sda_oe = 1'b0;
            n.st     = S_ACK_T;
          end
        end
      end
      S_ACK_T: begin
        if (rise) begin
          n.nack = r.sda_s2;
          n.idx  = r.idx + 4'h1;
          if (r.idx == 4'(FRAME_BYTES - 1)) begin
            n.pend_n = 1'b1; // RULE_06
          end
        end else if (fall) begin
          if (r.nack || r.idx == 4'(FRAME_BYTES)) begin
            n.st = S_IDLE;
          end else begin
            n.sh     = r.rep[r.idx];
            n.sda_oe = ~r.rep[r.idx][7];
            n.bits   = 4'h1;
            n.st     = S_TX;
          end
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase

    // start and stop override any bit-level step
    if (stop) begin
      if (r.st != S_IDLE && !r.rw && !r.ovr
          && r.idx == 4'(FRAME_BYTES)) begin
        n.cmd_v = 1'b1; // RULE_03
      end
      n.st     = S_IDLE;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
    end else if (start && !r.uart && r.strapped) begin
      n.st     = S_ADDR;
      n.bits   = CNT_RST;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
    end

    // a load after the clear in the same cycle still wins
    if (reply_load && n.pend_n) begin
      n.rep    = reply_frame;
      n.pend_n = 1'b0; // RULE_04
    end

    //////////////////////////////////////////////////////////////////////
    // led stream: bits change on the falling edge of the 1 MHz clock
    n.loe_n = ~led_enable; // RULE_11
    if (r.ldiv == LED_DIV_W'(LED_HALF_CYCLES - 1)) begin
      n.ldiv = '0;
      n.lclk = ~r.lclk; // RULE_13
      if (r.lclk) begin
        if (r.lbit < 5'(LED_BITS)) begin
          n.lsel_n = 1'b0; // RULE_11
          n.ldat   = r.lpat[4'(LED_BITS - 1) - r.lbit[3:0]];
          n.lbit   = r.lbit + 5'h01;
        end else if (r.lbit == 5'(LED_BITS)) begin
          n.lsel_n = 1'b1;
          n.llat_n = 1'b0; // RULE_11
          n.lbit   = r.lbit + 5'h01;
        end else begin
          n.llat_n = 1'b1;
          n.lbit   = 5'h00;
          n.lpat   = led_pattern;
        end
      end
    end else begin
      n.ldiv = r.ldiv + LED_DIV_W'(1);
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.scl_s1 <= LINE_RST;
      r.scl_s2 <= LINE_RST;
      r.scl_d  <= LINE_RST;
      r.sda_s1 <= LINE_RST;
      r.sda_s2 <= LINE_RST;
      r.sda_d  <= LINE_RST;
      r.dis_s1 <= LINE_RST;
      r.dis_s2 <= LINE_RST;
      r.pend_n <= 1'b1; // RULE_14
      r.irq_n  <= 1'b1;
      r.sysv_n <= 1'b1;
      r.lsel_n <= 1'b1;
      r.llat_n <= 1'b1;
      r.loe_n  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; the pin drivers only ever pull low
  assign link.scl_dev_o      = 1'b0;
  assign link.scl_dev_oe     = r.scl_oe;
  assign link.sda_dev_o      = 1'b0;
  assign link.sda_dev_oe     = r.sda_oe;
  assign link.reply_ready_n  = r.pend_n; // RULE_04
  assign link.event_irq_n    = r.irq_n;
  assign cmd_frame           = r.cmd;
  assign cmd_valid           = r.cmd_v;
  assign reply_pending       = ~r.pend_n;
  assign uart_mode           = r.uart;
  assign ports_off           = r.off;
  assign fan_on              = r.fan;
  assign system_valid_n      = r.sysv_n;
  assign manager_bus_clock   = r.lclk;
  assign led_serial_data     = r.ldat;
  assign led_select_n        = r.lsel_n;
  assign led_latch_n         = r.llat_n;
  assign led_output_enable_n = r.loe_n;

endmodule

// ---- msg_port_pkg.sv ----
/*
 * shared constants and types for the host message port: frame size,
 * serial clock timing, address strap levels and led stream timing.
 * assumes a 200 MHz host clock and a 31.25 MHz device (link) clock.
 */
package msg_port_pkg;

  // every message is a fixed frame, byte 0 travels first
  localparam int FRAME_BYTES = 15;
  typedef logic [FRAME_BYTES-1:0][7:0] frame_type;

  //////////////////////////////////////////////////////////////////////////
  // clocks and serial timing
  localparam int CORE_CLK_HZ = 200_000_000;
  localparam int LINK_CLK_HZ = 31_250_000;
  localparam int SCL_MAX_HZ  = 400_000;
  // least half period, rounded up so the rate never exceeds the limit
  localparam int SCL_HALF_CYCLES =
    (CORE_CLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ);
  localparam int TMR_W = 9;
  localparam int LED_CLK_HZ = 1_000_000;
  localparam int LED_HALF_CYCLES = LINK_CLK_HZ / (2 * LED_CLK_HZ);
  localparam int LED_DIV_W = 4;
  localparam int LED_BITS = 16;

  //////////////////////////////////////////////////////////////////////////
  // address strap: levels up to this code select uart operation
  localparam logic [7:0] UART_LEVEL_MAX = 8'h1f;
  localparam logic [6:0] ADDR_BASE      = 7'h28;

  // values after reset
  localparam logic [3:0] CNT_RST  = 4'h0;
  localparam logic       LINE_RST = 1'b1;

endpackage

// ---- host_link_if.sv ----
/*
 * wires between the host master and the device: open-drain serial
 * clock and data with a pull-up, plus the two status lines.
 * assumes each end drives only its own output and enable signals.
 */
`timescale 1ns/1ps
interface host_link_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic scl_dev_o;
  logic scl_dev_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic reply_ready_n;
  logic event_irq_n;
  logic host_serial_clock;
  logic host_serial_data;

  // wired-and with pull-up: any enabled low driver wins
  assign host_serial_clock = (scl_host_oe ? scl_host_o : 1'b1)
                           & (scl_dev_oe ? scl_dev_o : 1'b1);
  assign host_serial_data  = (sda_host_oe ? sda_host_o : 1'b1)
                           & (sda_dev_oe ? sda_dev_o : 1'b1);

  modport device (
    input  host_serial_clock, host_serial_data,
    output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe,
    output reply_ready_n, event_irq_n
  );

  modport host (
    input  host_serial_clock, host_serial_data,
    input  reply_ready_n, event_irq_n,
    output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe
  );
endinterface

// ---- msg_port_host.sv ----
/*
 * host end: serial master that writes or reads one fixed frame,
 * making the serial clock from core_clk by a divider.
 * assumes request inputs come from logic on core_clk.
 */
`timescale 1ns/1ps
module msg_port_host
  import msg_port_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // serial link
  host_link_if.host                link,
  // request side
  input  wire logic                req,
  input  wire logic                req_read,
  input  wire logic [6:0]          req_addr,
  input  wire msg_port_pkg::frame_type req_frame,
  output      logic                busy,
  output      logic                done,
  output      logic                error,
  output      logic                refused,
  output      msg_port_pkg::frame_type rd_frame,
  output      logic                irq_seen_n
);
  import msg_port_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_START, H_LOW, H_HIGH, H_STOP_A, H_STOP_B, H_STOP_C
  } mst_state_type;

  typedef struct packed {
    mst_state_type    st;
    logic             scl_s1;
    logic             scl_s2;
    logic             sda_s1;
    logic             sda_s2;
    logic             rdy_s1;
    logic             rdy_s2;
    logic             irq_s1;
    logic             irq_s2;
    logic [TMR_W-1:0] tmr;
    logic [4:0]       k;
    logic [3:0]       j;
    logic             rw;
    logic [7:0]       sh;
    frame_type        wfr;
    frame_type        rfr;
    logic             scl_oe;
    logic             sda_oe;
    logic             busy;
    logic             done;
    logic             err;
    logic             refused;
  } mst_state_type_all_type;

  mst_state_type_all_type r;
  mst_state_type_all_type n;
  logic                   half_end;
  logic                   wr_byte;

  // true when the host pulls the data line low for bit j of byte k
  function automatic logic drive_low(input logic [4:0] k,
                                     input logic [3:0] j,
                                     input logic       rw,
                                     input logic [7:0] sh);
    logic wr;
    wr = (k == 5'h00) || !rw;
    if (j < 4'h8) begin
      drive_low = wr ? ~sh[3'(4'h7 - j)] : 1'b0;
    end else begin
      // read ack: low on every byte but the last, which is refused
      drive_low = wr ? 1'b0 : (k != 5'(FRAME_BYTES));
    end
  endfunction

  assign half_end = (r.tmr == TMR_W'(SCL_HALF_CYCLES - 1)); // RULE_01
  assign wr_byte  = (r.k == 5'h00) || !r.rw;

  always_comb begin
    n = r;
    n.done    = 1'b0;
    n.refused = 1'b0;
    n.scl_s1  = link.host_serial_clock;
    n.scl_s2  = r.scl_s1;
    n.sda_s1  = link.host_serial_data;
    n.sda_s2  = r.sda_s1;
    n.rdy_s1  = link.reply_ready_n;
    n.rdy_s2  = r.rdy_s1;
    n.irq_s1  = link.event_irq_n;
    n.irq_s2  = r.irq_s1;
    n.tmr     = r.tmr + TMR_W'(1);
    case (r.st)
      H_IDLE: begin
        n.tmr = '0;
        if (req) begin
          if (req_read && r.rdy_s2) begin
            n.refused = 1'b1; // RULE_05
          end else begin
            n.st     = H_START;
            n.busy   = 1'b1;
            n.err    = 1'b0;
            n.rw     = req_read;
            n.wfr    = req_frame;
            n.sh     = {req_addr, req_read};
            n.k      = 5'h00;
            n.j      = CNT_RST;
            n.sda_oe = 1'b1;
          end
        end
      end
      H_START: begin
        if (half_end) begin
          n.st     = H_LOW;
          n.scl_oe = 1'b1;
          n.tmr    = '0;
        end
      end
      H_LOW: begin
        if (r.tmr == '0) begin
          n.sda_oe = drive_low(r.k, r.j, r.rw, r.sh);
        end
        if (half_end) begin
          n.st     = H_HIGH;
          n.scl_oe = 1'b0;
          n.tmr    = '0;
        end
      end
      H_HIGH: begin
        if (r.tmr == '0 && !r.scl_s2) begin
          n.tmr = '0; // RULE_02
        end else if (half_end) begin
          n.tmr    = '0;
          n.st     = H_LOW;
          n.scl_oe = 1'b1;
          if (r.j < 4'h8) begin
            if (!wr_byte) begin
              n.sh = {r.sh[6:0], r.sda_s2};
            end
            n.j = r.j + 4'h1;
          end else if (wr_byte && r.sda_s2) begin
            n.err = 1'b1;
            n.st  = H_STOP_A;
          end else begin
            if (!wr_byte) begin
              n.rfr[4'(r.k - 5'h01)] = r.sh;
            end
            if (r.k == 5'(FRAME_BYTES)) begin
              n.st = H_STOP_A; // RULE_03
            end else begin
              n.k  = r.k + 5'h01;
              n.j  = CNT_RST;
              n.sh = r.rw ? 8'h00 : r.wfr[r.k[3:0]];
            end
          end
        end
      end
      H_STOP_A: begin
        n.sda_oe = 1'b1;
        if (half_end) begin
          n.st     = H_STOP_B;
          n.scl_oe = 1'b0;
          n.tmr    = '0;
        end
      end
      H_STOP_B: begin
        if (r.tmr == '0 && !r.scl_s2) begin
          n.tmr = '0; // RULE_02
        end else if (half_end) begin
          n.st     = H_STOP_C;
          n.sda_oe = 1'b0;
          n.tmr    = '0;
        end
      end
      H_STOP_C: begin
        if (half_end) begin
          n.st   = H_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.scl_s1 <= LINE_RST;
      r.scl_s2 <= LINE_RST;
      r.sda_s1 <= LINE_RST;
      r.sda_s2 <= LINE_RST;
      r.rdy_s1 <= LINE_RST;
      r.rdy_s2 <= LINE_RST;
      r.irq_s1 <= LINE_RST;
      r.irq_s2 <= LINE_RST;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign link.scl_host_o  = 1'b0;
  assign link.scl_host_oe = r.scl_oe;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = r.sda_oe;
  assign busy             = r.busy;
  assign done             = r.done;
  assign error            = r.err;
  assign refused          = r.refused;
  assign rd_frame         = r.rfr;
  assign irq_seen_n       = r.irq_s2;

endmodule

// ---- msg_port_monitor.sv ----
/*
 * checker on the host link wires: serial rate, framing, reply flag.
 * assumes plain copies of the link signals and one shared reset.
 */
`timescale 1ns/1ps
module msg_port_monitor
  import msg_port_pkg::*;
(
  // clocks and reset
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  // link wires
  input wire logic host_serial_clock,
  input wire logic host_serial_data,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic reply_ready_n
);
  logic       scl_reg, sda_reg, rd_reg, start, stop, rise;
  logic [7:0] bit_reg;
  logic [9:0] per_reg;

  assign start = scl_reg & host_serial_clock & sda_reg & ~host_serial_data;
  assign stop  = scl_reg & host_serial_clock & ~sda_reg & host_serial_data;
  assign rise  = ~scl_reg & host_serial_clock;

  ////////////////////////////////////////////////////////////////////////////
  // period count saturates so a long idle never looks like a fast clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      rd_reg  <= 1'b0;
      bit_reg <= 8'h0;
      per_reg <= 10'h3ff;
    end else begin
      scl_reg <= host_serial_clock;
      sda_reg <= host_serial_data;
      per_reg <= rise ? 10'h0 : per_reg + 10'(per_reg != 10'h3ff);
      bit_reg <= start ? 8'h0 : bit_reg + 8'(rise);
      if (start || (rise && bit_reg == 8'h7)) begin
        rd_reg <= host_serial_data & ~start;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_scl_period: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rise |-> int'(per_reg) >= 2 * SCL_HALF_CYCLES - 1)
    else $error("serial clock period too short");
  a_start_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    start |-> host_serial_clock [*8] ##[1:300] !host_serial_clock)
    else $error("start condition timing wrong");
  a_sda_wait: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !scl_host_oe && !host_serial_clock && !scl_reg |-> $stable(sda_host_oe))
    else $error("host moved data while clock held low");
  a_frame_end: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stop |-> bit_reg == 8'h91 || bit_reg == 8'h0a)
    else $error("frame length wrong at stop");
  a_last_ack: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rise && bit_reg == 8'h8f |-> host_serial_data == rd_reg)
    else $error("last byte acknowledge wrong");
  a_read_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rise && bit_reg == 8'h7 && host_serial_data |-> !reply_ready_n)
    else $error("read started with no reply ready");
  a_ready_release: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    $rose(reply_ready_n) |-> rd_reg && bit_reg == 8'h90)
    else $error("reply flag released outside a full read");
  a_ready_reset: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    $rose(rst_n) |-> reply_ready_n)
    else $error("reply flag low after reset");
endmodule

// ---- host_message_port_and_system_signals_bench.sv ----
/*
 * bench: host end and device end joined by one link, both user sides
 * driven and checked here.
 * assumes the shared package; no outside stimulus.
 */
`timescale 1ns/1ps
module host_message_port_and_system_signals_bench;
  import msg_port_pkg::*;
  logic        core_clk, link_clk, rst_n, req, req_read, busy, done;
  logic        error, refused, irq_seen_n, cmd_valid, reply_load;
  logic        reply_pending, uart_mode, fan_request, port_shutdown_n;
  logic        ports_off, fan_on, system_valid_n, led_enable;
  logic        manager_bus_clock, led_serial_data, led_select_n;
  logic        led_latch_n, led_output_enable_n;
  logic [6:0]  req_addr;
  logic [7:0]  address_select_level_in, event_active, event_enable;
  logic [7:0]  sys_cond_ok, sys_mask;
  logic [15:0] led_pattern, bits;
  frame_type   req_frame, rd_frame, cmd_frame, reply_frame;
  int          err_count, cmp_count, cyc, cmd_seen;

  host_link_if link ();
  msg_port_device msg_port_device_inst (.*);
  msg_port_host msg_port_host_inst (.*);
  msg_port_monitor msg_port_monitor_inst (
    .core_clk(core_clk), .link_clk(link_clk), .rst_n(rst_n),
    .host_serial_clock(link.host_serial_clock),
    .host_serial_data(link.host_serial_data),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe),
    .reply_ready_n(link.reply_ready_n));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // two full frames take about 150k cycles; leave margin above that
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 200000) begin
      err_count++;
      stop_test();
    end
  end
  always @(posedge link_clk) cmd_seen += int'(cmd_valid === 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string name, logic [119:0] exp, logic [119:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic ltick(int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  // reset outlasts two link edges so the strap is taken cleanly
  task automatic do_reset(logic [7:0] lv);
    rst_n = 1'b0;
    address_select_level_in = lv;
    tick(5);
    ltick(2);
    tick(1);
    rst_n = 1'b1;
    tick(40);
  endtask
  task automatic xfer(logic rd, logic [6:0] a, frame_type fr);
    int n = 0;
    tick(1);
    req = 1'b1;
    req_read = rd;
    req_addr = a;
    req_frame = fr;
    tick(1);
    req = 1'b0;
    while (done !== 1'b1 && n < 80000) begin
      tick(1);
      n++;
    end
    check("done", 1, done);
    check("busy", 0, busy);
    tick(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_refuse();
    logic seen = 1'b0;
    tick(1);
    req = 1'b1;
    req_read = 1'b1;
    tick(1);
    req = 1'b0;
    repeat (3) begin
      seen |= refused;
      tick(1);
    end
    check("refused", 1, seen);
    check("idle data", 1, link.host_serial_data);
  endtask
  task automatic t_frames();
    frame_type fr;
    for (int i = 0; i < FRAME_BYTES; i++)
      fr[i] = 8'ha0 + 8'(i);
    xfer(1'b0, 7'h28, fr);
    check("wrong addr", 1, error);
    xfer(1'b0, 7'h2a, fr);
    ltick(3);
    check("write error", 0, error);
    check("command", fr, cmd_frame);
    check("command count", 1, cmd_seen);
    reply_frame = ~fr;
    reply_load = 1'b1;
    ltick(1);
    reply_load = 1'b0;
    ltick(1);
    check("ready low", 0, link.reply_ready_n);
    check("pending", 1, reply_pending);
    xfer(1'b1, 7'h2a, '0);
    check("reply", ~fr, rd_frame);
    check("ready high", 1, link.reply_ready_n);
  endtask
  task automatic t_side();
    event_enable = 8'h0c;
    event_active = 8'h04;
    sys_mask = 8'h0f;
    sys_cond_ok = 8'h0f;
    fan_request = 1'b1;
    port_shutdown_n = 1'b0;
    ltick(4);
    check("irq on", 0, link.event_irq_n);
    check("irq host", 0, irq_seen_n);
    check("valid", 0, system_valid_n);
    check("fan on", 1, fan_on);
    check("ports off", 1, ports_off);
    event_active = 8'h03;
    sys_cond_ok = 8'hf7;
    fan_request = 1'b0;
    port_shutdown_n = 1'b1;
    ltick(4);
    check("irq off", 1, link.event_irq_n);
    check("invalid", 1, system_valid_n);
    check("fan off", 0, fan_on);
    check("ports on", 0, ports_off);
  endtask
  task automatic t_led();
    int n = 0;
    led_enable = 1'b1;
    @(posedge led_select_n);
    @(negedge led_select_n);
    for (int i = 15; i >= 0; i--) begin
      @(posedge manager_bus_clock);
      bits[i] = led_serial_data;
      if (i == 15) begin
        do begin
          ltick(1);
          n++;
        end while (manager_bus_clock === 1'b1);
      end
    end
    check("led half period", LED_HALF_CYCLES, n);
    check("led bits", led_pattern, bits);
    n = 0;
    while (led_latch_n !== 1'b0 && n < 100) begin
      ltick(1);
      n++;
    end
    check("led latch", 0, led_latch_n);
    check("led enable", 0, led_output_enable_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {req, req_read, reply_load, fan_request, led_enable} = '0;
    {event_active, event_enable, sys_cond_ok, sys_mask} = '0;
    port_shutdown_n = 1'b1;
    req_addr = '0;
    req_frame = '0;
    reply_frame = '0;
    led_pattern = 16'ha53c;
    do_reset(8'h40);
    check("ready reset", 1, link.reply_ready_n);
    check("uart off", 0, uart_mode);
    t_refuse();
    t_frames();
    t_side();
    t_led();
    do_reset(8'h1f);
    check("uart on", 1, uart_mode);
    stop_test();
  end
endmodule
